//--- verilog/tcd_top.sv
/*
 * Channel-0 C/D I/O control, interrupt enables, status flags and the two
 * capture/compare units for general registers C and D.
 * Assumes: counter, channel-1 count event, buffer-mode bits and A/B match
 * events come from timer logic on CLK; pins C and D are asynchronous.
 */

// Notes on behaviour
// R1: upper nibble selects register D function
// R2: lower nibble selects register C function
// R3: x000 disables pin; x001 drives low
// R4: x010 drives pin high on match
// R5: x011 toggles pin on match
// R6: 1000 rising, 1001 falling pin capture
// R7: 101x captures on both pin edges
// R8: 11xx captures on channel 1 count
// R9: buffer mode B disables register D
// R10: buffer mode A disables register C
// R11: bit 7 gates converter start requests
// R12: bit 4 enables overflow interrupt
// R13: bit 3 enables register D interrupt
// R14: bit 2 enables register C interrupt
// R15: bit 1 enables register B interrupt
// R16: bit 0 enables register A interrupt
// R17: flags set on match or capture
// R18: overflow flag set on counter wrap
// R19: clear by read-one then write-zero
// R20: request equals flag and enable; reserved zero

`timescale 1ns/100ps
`default_nettype none
`include "tcd_consts.svh"

module tcd_top
    import tcd_pkg::*;
#(
    parameter int AW = 32,
    parameter int DW = 16
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [AW-1:0] ADDR,
    input wire logic [DW-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [DW-1:0] RDATA,

    input wire logic [DW-1:0] COUNTER,
    input wire logic CH1_COUNT,
    input wire logic BUF_MODE_A,
    input wire logic BUF_MODE_B,
    input wire logic MATCH_A_EVT,
    input wire logic MATCH_B_EVT,

    input wire logic PIN_C_I,
    output logic PIN_C_O,
    output logic PIN_C_OE,
    input wire logic PIN_D_I,
    output logic PIN_D_O,
    output logic PIN_D_OE,

    output logic IRQ_A,
    output logic IRQ_B,
    output logic IRQ_C,
    output logic IRQ_D,
    output logic IRQ_OVF,
    output logic CONV_START
);

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    localparam int NU = 2;

    logic sel_ioctl;
    logic sel_ier;
    logic sel_stat;
    logic sel_grc;
    logic sel_grd;

    logic [7:0] ier_q;
    logic [`TCD_NFLAGS-1:0] flags_q;
    logic [`TCD_NFLAGS-1:0] flags_d;
    logic [`TCD_NFLAGS-1:0] armed_q;
    logic [`TCD_NFLAGS-1:0] flag_set;
    logic [`TCD_NFLAGS-1:0] flag_clr;

    logic [DW-1:0] cnt_prev_q;
    logic cnt_new;
    logic overflow_evt;
    logic conv_q;
    logic [DW-1:0] rdata_q;
    logic [DW-1:0] rdata_d;

    logic [NU-1:0] pin_raw;
    logic [NU-1:0] sync1_q;
    logic [NU-1:0] sync2_q;

    logic [NU-1:0] unit_inhibit;
    logic [NU-1:0] unit_field_wr;
    logic [NU-1:0] unit_gr_wr;
    logic [NU-1:0] unit_pin_o;
    logic [NU-1:0] unit_pin_oe;
    logic [NU-1:0] unit_flag_evt;
    tcd_field_t unit_field [NU];
    logic [DW-1:0] unit_gr [NU];

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    // exact byte-address compare; anything else reads zero and writes nothing
    assign sel_ioctl = (ADDR == `TCD_ADDR_IOCTL);
    assign sel_ier = (ADDR == `TCD_ADDR_IER);
    assign sel_stat = (ADDR == `TCD_ADDR_STAT);
    assign sel_grc = (ADDR == `TCD_ADDR_GRC);
    assign sel_grd = (ADDR == `TCD_ADDR_GRD);

    // unit 0 is register C, unit 1 is register D
    assign unit_field_wr[0] = WR && sel_ioctl; // R2
    assign unit_field_wr[1] = WR && sel_ioctl; // R1
    assign unit_gr_wr[0] = WR && sel_grc;
    assign unit_gr_wr[1] = WR && sel_grd;
    assign unit_inhibit[0] = BUF_MODE_A; // R10
    assign unit_inhibit[1] = BUF_MODE_B; // R9
    assign pin_raw[0] = PIN_C_I;
    assign pin_raw[1] = PIN_D_I;

    // ------------------------------------------------------------------------
    // pin synchronisers and units
    // ------------------------------------------------------------------------
    // two flops per pin; only the second flop feeds the edge detector
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NU; gi++)
        begin : g_unit
            localparam int LSB = (gi == 0) ? `TCD_FIELD_C_LSB : `TCD_FIELD_D_LSB;
            tcd_unit #(
                .W(DW)
            ) u_unit (
                .clk(CLK),
                .rst(RST),
                .field_wr(unit_field_wr[gi]),
                .field_wdata(WDATA[LSB +: `TCD_FIELD_W]), // R1 R2
                .inhibit(unit_inhibit[gi]),
                .gr_wr(unit_gr_wr[gi]),
                .gr_wdata(WDATA),
                .cnt(COUNTER),
                .cnt_new(cnt_new),
                .pin_in(sync2_q[gi]),
                .ch1_evt(CH1_COUNT),
                .field_q(unit_field[gi]),
                .gr_q(unit_gr[gi]),
                .pin_o(unit_pin_o[gi]),
                .pin_oe(unit_pin_oe[gi]),
                .flag_evt(unit_flag_evt[gi])
            );
        end
    endgenerate

    // pin levels come straight from the unit flops; pin enables are decoded from the field and buffer mode
    assign PIN_C_O = unit_pin_o[0];
    assign PIN_C_OE = unit_pin_oe[0];
    assign PIN_D_O = unit_pin_o[1];
    assign PIN_D_OE = unit_pin_oe[1];

    // ------------------------------------------------------------------------
    // counter watch
    // ------------------------------------------------------------------------
    // previous counter value gives both the change strobe and the wrap event
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            cnt_prev_q <= DW'(`TCD_CNT_ZERO);
        else
            cnt_prev_q <= COUNTER;
    end

    assign cnt_new = (COUNTER != cnt_prev_q);
    assign overflow_evt = (cnt_prev_q == `TCD_CNT_MAX) &&
                          (COUNTER == `TCD_CNT_ZERO); // R18

    // ------------------------------------------------------------------------
    // interrupt enable register
    // ------------------------------------------------------------------------
    // bits 6 and 5 are masked off, so they neither store nor read back
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            ier_q <= `TCD_RST_IER;
        else if (WR && sel_ier)
            ier_q <= WDATA[7:0] & `TCD_IER_MASK; // R20
    end

    // ------------------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------------------
    // A/B events come from the timer, C/D from the units
    always_comb
    begin
        flag_set = '0;
        flag_set[`TCD_FLAG_A] = MATCH_A_EVT; // R17
        flag_set[`TCD_FLAG_B] = MATCH_B_EVT; // R17
        flag_set[`TCD_FLAG_C] = unit_flag_evt[0]; // R17
        flag_set[`TCD_FLAG_D] = unit_flag_evt[1]; // R17
        flag_set[`TCD_FLAG_OVF] = overflow_evt; // R18
    end

    // a zero written clears only a flag seen as one by an earlier read;
    // writing one does nothing, and a new event in the clear cycle survives
    assign flag_clr = (WR && sel_stat) ? (armed_q & ~WDATA[`TCD_NFLAGS-1:0]) : '0; // R19
    assign flags_d = (flags_q & ~flag_clr) | flag_set;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            flags_q <= '0;
        else
            flags_q <= flags_d;
    end

    // arming: a status read latches which flags were one; any status write
    // consumes the arming so a stale read cannot clear a later event
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            armed_q <= '0;
        else if (WR && sel_stat)
            armed_q <= '0; // R19
        else if (RD && sel_stat)
            armed_q <= armed_q | flags_q; // R19
    end

    // ------------------------------------------------------------------------
    // interrupt and trigger outputs
    // ------------------------------------------------------------------------
    // requests are plain ANDs of flops, so they follow flag and enable exactly
    assign IRQ_A = flags_q[`TCD_FLAG_A] & ier_q[`TCD_IER_A]; // R16 R20
    assign IRQ_B = flags_q[`TCD_FLAG_B] & ier_q[`TCD_IER_B]; // R15 R20
    assign IRQ_C = flags_q[`TCD_FLAG_C] & ier_q[`TCD_IER_C]; // R14 R20
    assign IRQ_D = flags_q[`TCD_FLAG_D] & ier_q[`TCD_IER_D]; // R13 R20
    assign IRQ_OVF = flags_q[`TCD_FLAG_OVF] & ier_q[`TCD_IER_OVF]; // R12 R20

    // converter start follows register A events, one cycle late
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            conv_q <= 1'b0;
        else
            conv_q <= MATCH_A_EVT & ier_q[`TCD_IER_TRIG]; // R11
    end

    assign CONV_START = conv_q;

    // ------------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------------
    // read data is valid only in the cycle after the strobe, zero otherwise
    always_comb
    begin
        rdata_d = '0;
        if (RD)
        begin
            if (sel_ioctl)
                rdata_d[7:0] = {unit_field[1], unit_field[0]};
            else if (sel_ier)
                rdata_d[7:0] = ier_q; // R20
            else if (sel_stat)
                rdata_d[7:0] = `TCD_STAT_FIXED | {3'b000, flags_q};
            else if (sel_grc)
                rdata_d = unit_gr[0];
            else if (sel_grd)
                rdata_d = unit_gr[1];
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            rdata_q <= '0; // idle bus reads zero
        else
            rdata_q <= rdata_d;
    end

    assign RDATA = rdata_q;

endmodule // tcd_top

`default_nettype wire

//--- verilog/tcd_consts.svh
/*
 * Constants for the channel-0 C/D capture/compare control block: register byte
 * addresses, field positions, reset values and fixed masks.
 * Assumes it is included by bare name from the package and the design files.
 */
`ifndef TCD_CONSTS_SVH
`define TCD_CONSTS_SVH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define TCD_ADDR_IOCTL 32'hFFFF_8263
`define TCD_ADDR_IER 32'hFFFF_8264
`define TCD_ADDR_STAT 32'hFFFF_8265
`define TCD_ADDR_GRC 32'hFFFF_826C
`define TCD_ADDR_GRD 32'hFFFF_826E

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define TCD_FIELD_W 4
`define TCD_FIELD_C_LSB 0
`define TCD_FIELD_D_LSB 4
`define TCD_IER_TRIG 7
`define TCD_IER_OVF 4
`define TCD_IER_D 3
`define TCD_IER_C 2
`define TCD_IER_B 1
`define TCD_IER_A 0
`define TCD_FLAG_A 0
`define TCD_FLAG_B 1
`define TCD_FLAG_C 2
`define TCD_FLAG_D 3
`define TCD_FLAG_OVF 4
`define TCD_NFLAGS 5

// ----------------------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------------------
`define TCD_RST_IOCTL 8'h00
`define TCD_RST_IER 8'h00
`define TCD_RST_GR 16'hFFFF
`define TCD_IER_MASK 8'h9F
`define TCD_STAT_FIXED 8'hC0
`define TCD_CNT_MAX 16'hFFFF
`define TCD_CNT_ZERO 16'h0000

`endif

//--- verilog/tcd_pkg.sv
/*
 * Types shared by the C/D capture/compare control block.
 * Assumes tcd_consts.svh is on the include path.
 */
`include "tcd_consts.svh"

package tcd_pkg;

    // ------------------------------------------------------------------------
    // function classes of a 4-bit field
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        TCD_FN_OFF,
        TCD_FN_CMP,
        TCD_FN_CAP_PIN,
        TCD_FN_CAP_CH1
    } tcd_fn_e;

    typedef logic [`TCD_FIELD_W-1:0] tcd_field_t;

endpackage

//--- verilog/tcd_unit.sv
/*
 * One capture/compare unit: function field, general register, pin level.
 * Assumes counter, change strobe, synchronised pin and channel-1 count event
 * all arrive on clk; the top decodes the register bus.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tcd_consts.svh"

module tcd_unit
    import tcd_pkg::*;
#(
    parameter int W = 16
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic field_wr,
    input wire logic [`TCD_FIELD_W-1:0] field_wdata,
    input wire logic inhibit,
    input wire logic gr_wr,
    input wire logic [W-1:0] gr_wdata,
    input wire logic [W-1:0] cnt,
    input wire logic cnt_new,
    input wire logic pin_in,
    input wire logic ch1_evt,
    output tcd_field_t field_q,
    output logic [W-1:0] gr_q,
    output logic pin_o,
    output logic pin_oe,
    output logic flag_evt
);

    tcd_fn_e fn;
    logic pin_prev_q;
    logic level_q;
    logic rise;
    logic fall;
    logic edge_hit;
    logic cmp_hit;
    logic cap_hit;

    // ------------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------------
    // buffer mode masks everything, so the field is stored but inert
    always_comb
    begin
        fn = TCD_FN_OFF;
        if (!inhibit) // R9 R10
        begin
            case (field_q[3:2])
                2'b00: fn = TCD_FN_CMP;
                2'b01: fn = TCD_FN_CMP;
                2'b10: fn = TCD_FN_CAP_PIN;
                2'b11: fn = TCD_FN_CAP_CH1; // R8
                default: fn = TCD_FN_OFF;
            endcase
        end
    end

    // edge detect on the already synchronised pin
    assign rise = pin_in & ~pin_prev_q;
    assign fall = ~pin_in & pin_prev_q;

    // one selection per capture code; both-edge covers x01x
    always_comb
    begin
        edge_hit = 1'b0;
        case (field_q[1:0])
            2'b00: edge_hit = rise; // R6
            2'b01: edge_hit = fall; // R6
            2'b10: edge_hit = rise | fall; // R7
            2'b11: edge_hit = rise | fall; // R7
            default: edge_hit = 1'b0;
        endcase
    end

    // match only when the counter has just taken a new value, so a stalled
    // counter sitting on the compare value raises a single event
    assign cmp_hit = (fn == TCD_FN_CMP) && cnt_new && (cnt == gr_q);
    assign cap_hit = ((fn == TCD_FN_CAP_PIN) && edge_hit) ||
                     ((fn == TCD_FN_CAP_CH1) && ch1_evt); // R6 R7 R8
    assign flag_evt = cmp_hit | cap_hit; // R17

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    // function field
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            field_q <= tcd_field_t'(`TCD_RST_IOCTL >> 4);
        else if (field_wr)
            field_q <= field_wdata;
    end

    // pin history for edge detection
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pin_prev_q <= 1'b0;
        else
            pin_prev_q <= pin_in;
    end

    // general register: capture beats a software write in the same cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            gr_q <= W'(`TCD_RST_GR);
        else if (cap_hit)
            gr_q <= cnt; // R6 R7 R8
        else if (gr_wr)
            gr_q <= gr_wdata;
    end

    // output level: initial level on field write, then match action
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            level_q <= 1'b0;
        else if (field_wr)
            level_q <= field_wdata[2]; // R3
        else if (cmp_hit)
        begin
            case (field_q[1:0])
                2'b01: level_q <= 1'b0; // R3
                2'b10: level_q <= 1'b1; // R4
                2'b11: level_q <= ~level_q; // R5
                default: level_q <= level_q;
            endcase
        end
    end

    // codes x000 keep the pin released
    assign pin_oe = (fn == TCD_FN_CMP) && (field_q[1:0] != 2'b00); // R3
    assign pin_o = level_q;

endmodule // tcd_unit

`default_nettype wire

//--- verification/tcd_top_chk.sv
/*
 * Checker for the C/D capture/compare control block, bound to tcd_top.
 * Assumes only the top ports are visible; enables are shadowed from writes.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tcd_consts.svh"

module tcd_top_chk #(
    parameter int AW = 32,
    parameter int DW = 16
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [AW-1:0] ADDR,
    input wire logic [DW-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [DW-1:0] RDATA,
    input wire logic [DW-1:0] COUNTER,
    input wire logic BUF_MODE_A,
    input wire logic BUF_MODE_B,
    input wire logic MATCH_A_EVT,
    input wire logic PIN_C_OE,
    input wire logic PIN_D_OE,
    input wire logic IRQ_A,
    input wire logic IRQ_B,
    input wire logic IRQ_C,
    input wire logic IRQ_D,
    input wire logic IRQ_OVF,
    input wire logic CONV_START
);
    logic [7:0] ier_q;
    logic ier_wr;

    // ------------------------------------------------------------------
    // shadow of the enable register
    // ------------------------------------------------------------------
    assign ier_wr = WR && (ADDR == `TCD_ADDR_IER);

    // reserved bits dropped so read-back can be checked too
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            ier_q <= `TCD_RST_IER;
        else if (ier_wr)
            ier_q <= WDATA[7:0] & `TCD_IER_MASK;
    end

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_irq_a_mask: assert property (!ier_q[0] |-> !IRQ_A)
        else $error("request A without enable");
    a_irq_b_mask: assert property (!ier_q[1] |-> !IRQ_B)
        else $error("request B without enable");
    a_irq_c_mask: assert property (!ier_q[2] |-> !IRQ_C)
        else $error("request C without enable");
    a_irq_d_mask: assert property (!ier_q[3] |-> !IRQ_D)
        else $error("request D without enable");
    a_irq_ovf_mask: assert property (!ier_q[4] |-> !IRQ_OVF)
        else $error("overflow request without enable");
    a_conv_start_gate: assert property (
        CONV_START == ($past(MATCH_A_EVT) && $past(ier_q[7])))
        else $error("converter start not gated by enable");
    a_ovf_wrap_sets: assert property ((COUNTER == 16'h0000) && ($past(COUNTER) == 16'hFFFF)
        && ier_q[4] && !ier_wr |=> IRQ_OVF)
        else $error("wrap did not raise overflow request");
    a_ier_read_back: assert property ($past(RD) && ($past(ADDR) == `TCD_ADDR_IER)
        |-> (RDATA[7:0] == $past(ier_q)) && (RDATA[DW-1:8] == '0))
        else $error("enable read-back wrong");
    a_buf_c_quiet: assert property (BUF_MODE_A && $past(BUF_MODE_A) |-> !PIN_C_OE)
        else $error("pin C driven in buffer mode");
    a_buf_d_quiet: assert property (BUF_MODE_B && $past(BUF_MODE_B) |-> !PIN_D_OE)
        else $error("pin D driven in buffer mode");
endmodule // tcd_top_chk

bind tcd_top tcd_top_chk #(.AW(AW), .DW(DW)) u_chk (
    .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .COUNTER(COUNTER), .BUF_MODE_A(BUF_MODE_A), .BUF_MODE_B(BUF_MODE_B),
    .MATCH_A_EVT(MATCH_A_EVT), .PIN_C_OE(PIN_C_OE), .PIN_D_OE(PIN_D_OE),
    .IRQ_A(IRQ_A), .IRQ_B(IRQ_B), .IRQ_C(IRQ_C), .IRQ_D(IRQ_D), .IRQ_OVF(IRQ_OVF),
    .CONV_START(CONV_START)
);

`default_nettype wire

//--- verification/tcd_pin_model.sv
/*
 * Far-side model of one timer pin: an outside source that yields to the block.
 * Assumes the outside source always drives, so the wire never floats.
 */
`timescale 1ns/100ps
`default_nettype none

module tcd_pin_model
(
    input wire logic drv_o,
    input wire logic drv_oe,
    input wire logic ext_lvl,
    output logic pin
);
    // block wins while it drives; otherwise the capture source sets the level
    assign pin = drv_oe ? drv_o : ext_lvl;
endmodule // tcd_pin_model

`default_nettype wire

//--- verification/tb_timer_ch0_cd_io_and_irq_enable.sv
/*
 * Self-checking bench for tcd_top: function codes, compare, capture, flags,
 * enables and reset. Assumes the checker is bound from its own file.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tcd_consts.svh"

`define TCD_CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
        end \
    end

module tb_timer_ch0_cd_io_and_irq_enable;
    typedef struct packed {logic [3:0] code; logic oe; logic lvl;} tcd_row_s;
    typedef struct packed {logic [3:0] code; logic lvl; logic [15:0] cnt;
        logic [15:0] exp;} tcd_cap_s;
    logic CLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0, CH1_COUNT = 1'b0, ext_c = 1'b0;
    logic BUF_MODE_A = 1'b0, BUF_MODE_B = 1'b0, MATCH_A_EVT = 1'b0, MATCH_B_EVT = 1'b0;
    logic [31:0] ADDR = 32'h0000_0000;
    logic [15:0] WDATA = 16'h0000, COUNTER = 16'h0000, RDATA, rd_v;
    logic PIN_C_I, PIN_C_O, PIN_C_OE, PIN_D_I, PIN_D_O, PIN_D_OE;
    logic IRQ_A, IRQ_B, IRQ_C, IRQ_D, IRQ_OVF, CONV_START;
    int failures = 0, check_count = 0, cyc = 0;
    // code, pin enabled, starting level
    tcd_row_s io_rows [16] = '{
        '{4'h0, 1'b0, 1'b0}, '{4'h1, 1'b1, 1'b0}, '{4'h2, 1'b1, 1'b0}, '{4'h3, 1'b1, 1'b0},
        '{4'h4, 1'b0, 1'b1}, '{4'h5, 1'b1, 1'b1}, '{4'h6, 1'b1, 1'b1}, '{4'h7, 1'b1, 1'b1},
        '{4'h8, 1'b0, 1'b0}, '{4'h9, 1'b0, 1'b0}, '{4'hA, 1'b0, 1'b0}, '{4'hB, 1'b0, 1'b0},
        '{4'hC, 1'b0, 1'b0}, '{4'hD, 1'b0, 1'b0}, '{4'hE, 1'b0, 1'b0}, '{4'hF, 1'b0, 1'b0}};
    // the third row is a rising edge under falling-only capture: no load
    tcd_cap_s cap_rows [5] = '{'{4'h8, 1'b1, 16'h1234, 16'h1234},
        '{4'h9, 1'b0, 16'h2222, 16'h2222}, '{4'h9, 1'b1, 16'h3333, 16'h2222},
        '{4'hA, 1'b0, 16'h4444, 16'h4444}, '{4'hB, 1'b1, 16'h5555, 16'h5555}};
    // bit 4 is the level after the match, low nibble the code
    logic [4:0] match_rows [4] = '{5'h05, 5'h12, 5'h13, 5'h07};

    tcd_top dut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .COUNTER(COUNTER), .CH1_COUNT(CH1_COUNT), .BUF_MODE_A(BUF_MODE_A),
        .BUF_MODE_B(BUF_MODE_B), .MATCH_A_EVT(MATCH_A_EVT), .MATCH_B_EVT(MATCH_B_EVT),
        .PIN_C_I(PIN_C_I), .PIN_C_O(PIN_C_O), .PIN_C_OE(PIN_C_OE), .PIN_D_I(PIN_D_I),
        .PIN_D_O(PIN_D_O), .PIN_D_OE(PIN_D_OE), .IRQ_A(IRQ_A), .IRQ_B(IRQ_B), .IRQ_C(IRQ_C),
        .IRQ_D(IRQ_D), .IRQ_OVF(IRQ_OVF), .CONV_START(CONV_START));
    tcd_pin_model u_pin_c (.drv_o(PIN_C_O), .drv_oe(PIN_C_OE), .ext_lvl(ext_c), .pin(PIN_C_I));
    tcd_pin_model u_pin_d (.drv_o(PIN_D_O), .drv_oe(PIN_D_OE), .ext_lvl(1'b0), .pin(PIN_D_I));

    // 40 MHz clock
    always #12.5 CLK = ~CLK;

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [31:0] a);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 rd_v = RDATA;
    endtask

    task automatic setcnt(input logic [15:0] v);
        @(posedge CLK);
        COUNTER <= v;
    endtask

    task automatic step();
        @(posedge CLK);
        #1;
    endtask

    task automatic pulse(input logic b);
        @(posedge CLK);
        if (b)
            MATCH_B_EVT <= 1'b1;
        else
            MATCH_A_EVT <= 1'b1;
        @(posedge CLK);
        MATCH_A_EVT <= 1'b0;
        MATCH_B_EVT <= 1'b0;
        #1;
    endtask

    initial
    begin
        repeat (10) @(posedge CLK);
        RST <= 1'b0;
        // every code in both fields: pin enable, start level, read-back
        foreach (io_rows[i])
        begin
            wr(`TCD_ADDR_IOCTL, {8'h00, io_rows[i].code, io_rows[i].code});
            #1 `TCD_CHK(PIN_C_OE, io_rows[i].oe)
            `TCD_CHK(PIN_D_OE, io_rows[i].oe)
            if (io_rows[i].oe)
                `TCD_CHK({PIN_C_O, PIN_D_O}, {2{io_rows[i].lvl}})
            rd(`TCD_ADDR_IOCTL);
            `TCD_CHK(rd_v, {8'h00, io_rows[i].code, io_rows[i].code})
        end
        // buffer mode masks compare on both registers
        wr(`TCD_ADDR_GRC, 16'h0010);
        wr(`TCD_ADDR_GRD, 16'h0010);
        wr(`TCD_ADDR_IER, 16'h000C);
        BUF_MODE_A <= 1'b1;
        BUF_MODE_B <= 1'b1;
        wr(`TCD_ADDR_IOCTL, 16'h0022);
        setcnt(16'h0010);
        step();
        `TCD_CHK({IRQ_C, PIN_C_OE}, 2'b00)
        `TCD_CHK({IRQ_D, PIN_D_OE}, 2'b00)
        @(posedge CLK);
        BUF_MODE_A <= 1'b0;
        BUF_MODE_B <= 1'b0;
        // compare actions on C while D sits at code 0
        foreach (match_rows[i])
        begin
            setcnt(16'h0000);
            wr(`TCD_ADDR_IOCTL, {12'h000, match_rows[i][3:0]});
            #1 `TCD_CHK(PIN_C_O, match_rows[i][2])
            setcnt(16'h0010);
            step();
            `TCD_CHK(PIN_C_O, match_rows[i][4])
            `TCD_CHK(IRQ_C, 1'b1)
        end
        `TCD_CHK(IRQ_D, 1'b1)
        // clearing needs a read first; a write of ones disarms
        rd(`TCD_ADDR_STAT);
        wr(`TCD_ADDR_STAT, 16'h00FF);
        wr(`TCD_ADDR_STAT, 16'h0000);
        #1 `TCD_CHK(IRQ_C, 1'b1)
        rd(`TCD_ADDR_STAT);
        `TCD_CHK(rd_v, 16'h00CC)
        wr(`TCD_ADDR_STAT, 16'h0000);
        step();
        `TCD_CHK({IRQ_C, IRQ_D}, 2'b00)
        // pin-edge capture
        foreach (cap_rows[i])
        begin
            setcnt(cap_rows[i].cnt);
            wr(`TCD_ADDR_IOCTL, {12'h000, cap_rows[i].code});
            @(posedge CLK);
            ext_c <= cap_rows[i].lvl;
            repeat (5) step();
            rd(`TCD_ADDR_GRC);
            `TCD_CHK(rd_v, cap_rows[i].exp)
        end
        // channel-1 count capture, all four codes
        for (int k = 12; k < 16; k++)
        begin
            setcnt(16'h7000 | 16'(k));
            wr(`TCD_ADDR_IOCTL, 16'(k));
            @(posedge CLK);
            CH1_COUNT <= 1'b1;
            @(posedge CLK);
            CH1_COUNT <= 1'b0;
            rd(`TCD_ADDR_GRC);
            `TCD_CHK(rd_v, 16'h7000 | 16'(k))
        end
        // converter start and A/B requests
        wr(`TCD_ADDR_IER, 16'h0080);
        pulse(1'b0);
        `TCD_CHK({CONV_START, IRQ_A}, 2'b10)
        wr(`TCD_ADDR_IER, 16'h0000);
        pulse(1'b0);
        `TCD_CHK(CONV_START, 1'b0)
        wr(`TCD_ADDR_IER, 16'h0003);
        #1 `TCD_CHK(IRQ_A, 1'b1)
        pulse(1'b1);
        `TCD_CHK(IRQ_B, 1'b1)
        // reserved bits, unmapped place, overflow
        wr(`TCD_ADDR_IER, 16'h00FF);
        rd(`TCD_ADDR_IER);
        `TCD_CHK(rd_v, 16'h009F)
        rd(32'hFFFF_8266);
        `TCD_CHK(rd_v, 16'h0000)
        setcnt(16'hFFFF);
        setcnt(16'h0000);
        step();
        `TCD_CHK(IRQ_OVF, 1'b1)
        // second reset in mid-run restores the I/O control, enable and status registers
        @(posedge CLK);
        RST <= 1'b1;
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        #1 `TCD_CHK({IRQ_A, IRQ_B, IRQ_C, IRQ_D, IRQ_OVF}, 5'h00)
        rd(`TCD_ADDR_IOCTL);
        `TCD_CHK(rd_v, 16'h0000)
        rd(`TCD_ADDR_IER);
        `TCD_CHK(rd_v, 16'h0000)
        rd(`TCD_ADDR_STAT);
        `TCD_CHK(rd_v, 16'h00C0)
        tally_and_finish();
    end
endmodule // tb_timer_ch0_cd_io_and_irq_enable

`default_nettype wire
